// ### rtl/idesbc_defs.vh
`ifndef IDESBC_DEFS_VH
`define IDESBC_DEFS_VH

// ==========================================================
// Primary disk map, 10-bit I/O addresses
`define IDESBC_CMD_BASE      10'h1f0
`define IDESBC_CTL_BASE      10'h3f0
`define IDESBC_DATA_ADDR     10'h1f0
`define IDESBC_GAME_ADDR     10'h201
// Device's own decode window (base, mask of compared bits)
`define IDESBC_OWN_BASE      10'h000
`define IDESBC_OWN_MASK      10'h000
// Configuration mode codes
`define IDESBC_MODE_SW_BOARD_MODE     2'h0
`define IDESBC_MODE_SW_ADDIN_MODE     2'h1
`define IDESBC_MODE_HWB      2'h2
`define IDESBC_MODE_HWE      2'h3
// Reset values
`define IDESBC_RST_SEL       2'h3
`define IDESBC_RST_ONE       1'h1
// Control select decodes only the 3f0h-3f7h block; regs 3f6h/3f7h live there
`define IDESBC_CTL_PAIR_LO   3'h6

`endif

// ### rtl/idesbc_sync.v
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Two-flop synchroniser, vector wide
module idesbc_sync #(
    parameter WIDTH = 1
) (
    input  wire             clk,
    input  wire             rstn,
    input  wire [WIDTH-1:0] din,
    output reg  [WIDTH-1:0] dout
);
    reg [WIDTH-1:0] meta;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta <= {WIDTH{1'b0}};
            dout <= {WIDTH{1'b0}};
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule // idesbc_sync

`default_nettype wire

// ### rtl/idesbc_top.v
`timescale 1ns/1ps
`default_nettype none
`include "idesbc_defs.vh"

// Overview of operation
// - Upper transceiver enable asserts on data register access when drive signals wide I/O.
// - Two active-low disk selects decoded from address bits 9:3, AEN and the IOR/IOW strobes.
// - All these pins are inputs while ISA reset is high, outputs otherwise.
// - Board mode: shared pin low when parallel bus drives, high when it receives.
// - Other modes: shared pin is active-low joystick select at address 201h.
// - Outside board mode the shared pin ignores parallel data direction.
module idesbc_top (
    input  wire       clk,
    input  wire       rstn,
    input  wire [9:0] isa_addr,
    input  wire       isa_aen,
    input  wire       isa_ior_n,
    input  wire       isa_iow_n,
    input  wire       isa_reset_drive,
    input  wire       drive_wide_io_n,
    input  wire [1:0] cfg_mode,
    input  wire       par_data_out,
    output reg  [1:0] disk_chip_sel_n,
    output reg  [1:0] disk_chip_sel_oe_n,
    output reg        low_buffer_enable_n,
    output reg        low_buffer_enable_oe_n,
    output reg        upper_xcvr_enable_n,
    output reg        upper_xcvr_enable_oe_n,
    output reg        shared_pin,
    output reg        shared_pin_oe_n,
    output wire       sw_board_mode
);

    // ==========================================================
    // Synchronise pins
    wire [9:0] addr_s;
    wire [5:0] ctl_s;
    wire       aen_s;
    wire       ior_n_s;
    wire       iow_n_s;
    wire       rst_s;
    wire       wide_n_s;
    wire       pdir_s;
    wire [1:0] cfg_s;

    // Strap pins come from off chip like the rest
    idesbc_sync #(.WIDTH(2)) u_sync_cfg (
        .clk  (clk),
        .rstn (rstn),
        .din  (cfg_mode),
        .dout (cfg_s)
    );

    idesbc_sync #(.WIDTH(10)) u_sync_addr (
        .clk  (clk),
        .rstn (rstn),
        .din  (isa_addr),
        .dout (addr_s)
    );

    idesbc_sync #(.WIDTH(6)) u_sync_ctl (
        .clk  (clk),
        .rstn (rstn),
        .din  ({isa_aen, isa_ior_n, isa_iow_n, isa_reset_drive,
                drive_wide_io_n, par_data_out}),
        .dout (ctl_s)
    );

    assign aen_s    = ctl_s[5];
    assign ior_n_s  = ctl_s[4];
    assign iow_n_s  = ctl_s[3];
    assign rst_s    = ctl_s[2];
    assign wide_n_s = ctl_s[1];
    assign pdir_s   = ctl_s[0];

    // ==========================================================
    // Decode
    function hit8;
        input [9:0] a;
        input [9:0] base;
        begin
            hit8 = (a[9:3] == base[9:3]);
        end
    endfunction

    wire [1:0] mode_s;
    reg  [1:0] mode;
    wire       io_cyc;
    wire       sel_cmd;
    wire       sel_ctl;
    wire       own_hit;
    wire       game_hit;
    wire       data_hit;

    assign io_cyc   = !aen_s && (!ior_n_s || !iow_n_s);
    assign sel_cmd  = io_cyc && hit8(addr_s, `IDESBC_CMD_BASE);
    assign sel_ctl  = io_cyc && hit8(addr_s, `IDESBC_CTL_BASE);
    assign own_hit  = io_cyc && ((addr_s & `IDESBC_OWN_MASK) ==
                                 (`IDESBC_OWN_BASE & `IDESBC_OWN_MASK));
    assign game_hit = io_cyc && (addr_s == `IDESBC_GAME_ADDR);
    assign data_hit = io_cyc && (addr_s == `IDESBC_DATA_ADDR);
    assign mode_s   = mode;
    assign sw_board_mode = (mode_s == `IDESBC_MODE_SW_BOARD_MODE);

    // Mode caught while reset drive is high, held afterwards
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mode <= `IDESBC_MODE_SW_BOARD_MODE;
        end else if (rst_s) begin
            mode <= cfg_s;
        end
    end

    // ==========================================================
    // Outputs
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            disk_chip_sel_n        <= `IDESBC_RST_SEL;
            disk_chip_sel_oe_n     <= `IDESBC_RST_SEL;
            low_buffer_enable_n    <= `IDESBC_RST_ONE;
            low_buffer_enable_oe_n <= `IDESBC_RST_ONE;
            upper_xcvr_enable_n    <= `IDESBC_RST_ONE;
            upper_xcvr_enable_oe_n <= `IDESBC_RST_ONE;
            shared_pin             <= `IDESBC_RST_ONE;
            shared_pin_oe_n        <= `IDESBC_RST_ONE;
        end else if (rst_s) begin
            disk_chip_sel_n        <= `IDESBC_RST_SEL;
            disk_chip_sel_oe_n     <= `IDESBC_RST_SEL;
            low_buffer_enable_n    <= `IDESBC_RST_ONE;
            low_buffer_enable_oe_n <= `IDESBC_RST_ONE;
            upper_xcvr_enable_n    <= `IDESBC_RST_ONE;
            upper_xcvr_enable_oe_n <= `IDESBC_RST_ONE;
            shared_pin             <= `IDESBC_RST_ONE;
            shared_pin_oe_n        <= `IDESBC_RST_ONE;
        end else begin
            disk_chip_sel_oe_n     <= 2'h0;
            low_buffer_enable_oe_n <= 1'b0;
            upper_xcvr_enable_oe_n <= 1'b0;
            shared_pin_oe_n        <= 1'b0;
            disk_chip_sel_n        <= {~sel_ctl, ~sel_cmd};
            low_buffer_enable_n    <= ~(own_hit || sel_cmd || sel_ctl || game_hit);
            upper_xcvr_enable_n    <= ~(data_hit && !wide_n_s);
            if (sw_board_mode) begin
                shared_pin <= ~pdir_s;
            end else begin
                shared_pin <= ~game_hit;
            end
        end
    end

endmodule // idesbc_top

`default_nettype wire

// ### dv/idesbc_drive.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Drive model
module idesbc_drive (
    input  wire logic       wide_ok,
    input  wire logic [1:0] sel_n,
    output logic            drive_wide_io_n
);
    assign drive_wide_io_n = !(wide_ok && !sel_n[0]);
endmodule // idesbc_drive
`default_nettype wire

// ### dv/idesbc_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module idesbc_asserts (
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic [9:0] isa_addr,
    input wire logic       isa_aen,
    input wire logic       isa_ior_n,
    input wire logic       isa_iow_n,
    input wire logic       isa_reset_drive,
    input wire logic       drive_wide_io_n,
    input wire logic       par_data_out,
    input wire logic [1:0] disk_chip_sel_n,
    input wire logic [1:0] disk_chip_sel_oe_n,
    input wire logic       low_buffer_enable_n,
    input wire logic       upper_xcvr_enable_n,
    input wire logic       shared_pin,
    input wire logic       shared_pin_oe_n,
    input wire logic       sw_board_mode
);
    logic [2:0] age;
    wire        on  = !isa_reset_drive;
    wire        acc = on && !isa_aen && !(isa_ior_n && isa_iow_n);
    // Past values reach into reset for a few edges
    always_ff @(posedge clk or negedge rstn)
        if (!rstn) age <= 3'h0;
        else if (age != 3'h7) age <= age + 3'h1;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn || age != 3'h7);
    sequence s_mode_settled;
        $stable(sw_board_mode) && sw_board_mode == $past(sw_board_mode, 2);
    endsequence
    a_cmd_sel: assert property (disk_chip_sel_n[0] == !$past(acc && isa_addr[9:3] == 7'h3e, 3))
        else $error("command select wrong");
    a_ctl_sel: assert property (disk_chip_sel_n[1] == !$past(acc && isa_addr[9:3] == 7'h7e, 3))
        else $error("control select wrong");
    a_sel_exclusive: assert property (disk_chip_sel_n != 2'h0)
        else $error("both selects low");
    a_buf_every: assert property (low_buffer_enable_n == !$past(acc, 3))
        else $error("buffer enable wrong");
    a_upper_wide: assert property (upper_xcvr_enable_n ==
        !$past(acc && isa_addr == 10'h1f0 && !drive_wide_io_n, 3))
        else $error("upper enable wrong");
    a_pins_released: assert property (shared_pin_oe_n == !$past(on, 3) &&
        disk_chip_sel_oe_n == {2{!$past(on, 3)}})
        else $error("pin enables wrong");
    a_board_dir: assert property (s_mode_settled ##0 sw_board_mode |->
        shared_pin == !$past(on && par_data_out, 3))
        else $error("direction wrong");
    a_game_sel: assert property (s_mode_settled ##0 !sw_board_mode |->
        shared_pin == !$past(acc && isa_addr == 10'h201, 3))
        else $error("game select wrong");
endmodule // idesbc_asserts
bind idesbc_top idesbc_asserts i_idesbc_asserts (.*);
`default_nettype wire

// ### dv/idesbc_test.sv
`timescale 1ns/1ps
`default_nettype none
module idesbc_test;
    logic       clk = 0, rstn = 0, aen = 0, ior_n = 1, iow_n = 1, rd = 0, wok = 0, pdo = 0;
    logic [9:0] ad = 10'h000;
    logic [1:0] md = 2'h0, cs, cs_oe;
    logic       lb, lb_oe, up, up_oe, sp, sp_oe, sbm, wide;
    int         error_cnt = 0, tests_run = 0;
    initial forever #12.5 clk = ~clk;
    idesbc_top i_idesbc_top (.clk(clk), .rstn(rstn), .isa_addr(ad), .isa_aen(aen),
        .isa_ior_n(ior_n), .isa_iow_n(iow_n), .isa_reset_drive(rd), .drive_wide_io_n(wide),
        .cfg_mode(md), .par_data_out(pdo), .disk_chip_sel_n(cs), .disk_chip_sel_oe_n(cs_oe),
        .low_buffer_enable_n(lb), .low_buffer_enable_oe_n(lb_oe), .upper_xcvr_enable_n(up),
        .upper_xcvr_enable_oe_n(up_oe), .shared_pin(sp), .shared_pin_oe_n(sp_oe),
        .sw_board_mode(sbm));
    idesbc_drive i_idesbc_drive (.wide_ok(wok), .sel_n(cs), .drive_wide_io_n(wide));
    task automatic go(input int n); repeat (n) @(posedge clk); endtask
    // Sample mid-cycle, away from the output edge
    task automatic chk(input logic [4:0] e);
        @(negedge clk); tests_run++;
        if ({cs, lb, up, sp} !== e) begin
            error_cnt++; $display("[FAIL] %0t pins %b", $time, {cs, lb, up, sp});
        end
        @(posedge clk);
    endtask
    task automatic chk_oe(input logic e);
        @(negedge clk); tests_run++;
        if ({cs_oe, lb_oe, up_oe, sp_oe} !== {5{e}}) begin
            error_cnt++; $display("[FAIL] %0t enables", $time);
        end
        @(posedge clk);
    endtask
    task automatic chk_mode(input logic e);
        @(negedge clk); tests_run++;
        if (sbm !== e) begin
            error_cnt++; $display("[FAIL] %0t mode flag %b", $time, sbm);
        end
        @(posedge clk);
    endtask
    task automatic io(input logic [9:0] a, input logic w, b, k, input logic [4:0] e);
        ad <= a; aen <= b; ior_n <= w; iow_n <= !w; wok <= k; go(8); chk(e);
        ior_n <= 1; iow_n <= 1; go(8); chk({4'hf, !pdo || (md != 2'h0)});
    endtask
    task automatic t_mode(input logic [1:0] m);
        md <= m; rd <= 1; ad <= 10'h1f0; ior_n <= 0; go(4); chk_oe(1); chk(5'h1f);
        rd <= 0; ior_n <= 1; go(8); chk_oe(0);
        chk_mode(m == 2'h0);
    endtask
    task automatic t_disk;
        t_mode(2'h0);
        io(10'h1f0, 0, 0, 1, 5'h11);
        io(10'h1f0, 1, 0, 0, 5'h13);
        io(10'h1f7, 0, 0, 1, 5'h13);
        io(10'h1f8, 0, 0, 1, 5'h1b);
        io(10'h3f6, 1, 0, 1, 5'h0b);
        io(10'h3f7, 0, 1, 1, 5'h1f);
        $display("disk done");
    endtask
    task automatic t_game;
        for (int i = 1; i < 4; i++) begin
            t_mode(i[1:0]); pdo <= 1;
            io(10'h201, 0, 0, 0, 5'h1a);
            io(10'h202, 1, 0, 0, 5'h1b);
        end
        $display("game done");
    endtask
    task automatic t_board;
        t_mode(2'h0); pdo <= 1; go(8); chk(5'h1e);
        pdo <= 0; io(10'h201, 0, 0, 0, 5'h1b);
        $display("board done");
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin go(2); rstn <= 1; go(2); t_disk(); t_game(); t_board(); end_of_test(); end
    initial begin go(3000); error_cnt++; end_of_test(); end
endmodule // idesbc_test
`default_nettype wire
